//--- core/fsrw_core.v
`timescale 1ns/1ps
`default_nettype none
`include "fsrw_map.vh"

module fsrw_core (
  input  wire        clk_sys_i,
  input  wire        rst_i,
  input  wire        cs_n_i,
  input  wire        sck_i,
  input  wire [3:0]  io_i,
  input  wire        prog_start_i,
  input  wire        erase_start_i,
  input  wire        op_finish_i,
  input  wire        nosusp_op_i,
  input  wire        rd_in_suspend_flag_area_i,
  input  wire        burst_load_i,
  input  wire [23:0] burst_addr_i,
  input  wire        burst_step_i,
  output wire        suspend_flag_o,
  output wire        erase_suspended_flag_o,
  output wire        program_suspended_flag_o,
  output wire        device_active_flag_o,
  output wire        run_program_o,
  output wire        run_erase_o,
  output wire        wrap_enable_o,
  output wire [1:0]  wrap_len_o,
  output wire [23:0] burst_addr_o,
  output wire        burst_section_done_o,
  output wire        rd_data_undefined_o
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_RUN  = 4'h2;
  localparam [3:0] ST_HALT = 4'h4;
  localparam [3:0] ST_RES  = 4'h8;

  localparam integer SUSPEND_FLAG_CYC = `FSRW_SUSPEND_FLAG_CYC;
  localparam integer RES_CYC  = `FSRW_RES_CYC;
  // counts must stay below 4096 for the 12-bit latency counter
  localparam [11:0]  SUSPEND_FLAG_CNT = SUSPEND_FLAG_CYC[11:0];
  localparam [11:0]  RES_CNT  = RES_CYC[11:0];

  //////////////////////////////////////////////////////////////////////////////
  // functions

  function [5:0] wrap_mask;
    input [1:0] sel;
    begin
      // 64-byte shift overflows to zero; minus one still yields the full mask
      wrap_mask = (6'h08 << sel) - 6'h01;
    end
  endfunction

  function [23:0] burst_next;
    input [23:0] a;
    input        dis;
    input [1:0]  sel;
    reg   [5:0]  m;
    reg   [5:0]  inc;
    begin
      m = wrap_mask(sel);
      inc = a[5:0] + 6'h01;
      if (dis) begin
        burst_next = a + 24'h000001;
      end else begin
        burst_next = {a[23:6], (a[5:0] & ~m) | (inc & m)};
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  reg  [5:0] s1_reg;
  reg  [5:0] s2_reg;
  reg        sck_d_reg;
  reg        cs_d_reg;

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg    <= 6'h01;
      s2_reg    <= 6'h01;
      sck_d_reg <= 1'b0;
      cs_d_reg  <= 1'b1;
    end else begin
      s1_reg    <= {io_i, sck_i, cs_n_i};
      s2_reg    <= s1_reg;
      sck_d_reg <= s2_reg[1];
      cs_d_reg  <= s2_reg[0];
    end
  end

  wire       cs_n_s  = s2_reg[0];
  wire       sck_s   = s2_reg[1];
  wire [3:0] io_s    = s2_reg[5:2];
  // sck edge found by sampling; fine for sck well below clk_sys/2
  wire       sck_rise = sck_s & ~sck_d_reg & ~cs_n_s;
  wire       cs_rise  = cs_n_s & ~cs_d_reg;

  //////////////////////////////////////////////////////////////////////////////
  // frame capture

  reg  [5:0] clk_cnt_reg;
  reg  [7:0] opc_reg;
  reg  [7:0] wbyte_reg;

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      clk_cnt_reg <= 6'h00;
      opc_reg     <= 8'h00;
      wbyte_reg   <= 8'h00;
    end else if (cs_n_s) begin
      clk_cnt_reg <= 6'h00;
    end else if (sck_rise) begin
      if (clk_cnt_reg != 6'h3f) begin
        clk_cnt_reg <= clk_cnt_reg + 6'h01;
      end
      if (clk_cnt_reg < `FSRW_OPC_CLKS) begin
        opc_reg <= {opc_reg[6:0], io_s[0]};
      end
      if (clk_cnt_reg == `FSRW_WRAP_HI_CLK - 6'h01) begin
        wbyte_reg[7:4] <= io_s;
      end
      if (clk_cnt_reg == `FSRW_WRAP_LO_CLK - 6'h01) begin
        wbyte_reg[3:0] <= io_s;
      end
    end
  end

  // count still holds the frame length in the cs rise cycle
  // byte boundary on single line
  wire single_ok = (clk_cnt_reg >= `FSRW_OPC_CLKS) && (clk_cnt_reg[2:0] == 3'h0);
  // quad phase: two clocks per byte after opcode
  wire quad_ok   = (clk_cnt_reg >= `FSRW_WRAP_LO_CLK) && ~clk_cnt_reg[0];

  // no write latch gating on suspend
  wire suspend_flag_cmd = cs_rise && single_ok &&
                  (opc_reg == `FSRW_OP_SUSPEND_FLAG_A || opc_reg == `FSRW_OP_SUSPEND_FLAG_B);
  // no write latch gating on resume
  wire res_cmd  = cs_rise && single_ok &&
                  (opc_reg == `FSRW_OP_RES_A || opc_reg == `FSRW_OP_RES_B);
  wire wrap_cmd = cs_rise && quad_ok && (opc_reg == `FSRW_OP_WRAP);

  //////////////////////////////////////////////////////////////////////////////
  // suspend / resume sequencer

  reg  [3:0]  st_reg;
  reg  [3:0]  st_next;
  reg  [11:0] lat_reg;
  reg  [11:0] lat_next;
  reg         kind_erase_reg;
  reg         kind_erase_next;
  reg         ps_reg;
  reg         ps_next;
  reg         es_reg;
  reg         es_next;
  reg         suspend_flag_reg;
  reg         suspend_flag_next;

  always @* begin
    st_next         = st_reg;
    lat_next        = lat_reg;
    kind_erase_next = kind_erase_reg;
    ps_next         = ps_reg;
    es_next         = es_reg;
    suspend_flag_next       = suspend_flag_reg;
    case (st_reg)
      ST_IDLE: begin
        // a locked op also holds off resume and new starts
        // resume needs a suspended flag and not busy
        if (res_cmd && (ps_reg || es_reg) && !nosusp_op_i) begin
          if (ps_reg) begin
            ps_next         = 1'b0;
            kind_erase_next = 1'b0;
            suspend_flag_next       = es_reg;
          end else begin
            es_next         = 1'b0;
            kind_erase_next = 1'b1;
            suspend_flag_next       = 1'b0;
          end
          st_next  = ST_RES;
          lat_next = RES_CNT - 12'h001;
        end else if (prog_start_i && !ps_reg && !nosusp_op_i) begin
          st_next         = ST_RUN;
          kind_erase_next = 1'b0;
        end else if (erase_start_i && !ps_reg && !es_reg && !nosusp_op_i) begin
          st_next         = ST_RUN;
          kind_erase_next = 1'b1;
        end
      end
      ST_RUN: begin
        if (op_finish_i) begin
          st_next = ST_IDLE;
        end else if (suspend_flag_cmd && !nosusp_op_i) begin
          st_next  = ST_HALT;
          lat_next = SUSPEND_FLAG_CNT - 12'h001;
        end
      end
      ST_HALT: begin
        // op_finish ignored here; the engine is already parked
        // flags set, busy cleared at halt
        if (lat_reg == 12'h000) begin
          st_next   = ST_IDLE;
          suspend_flag_next = 1'b1;
          if (kind_erase_reg) begin
            es_next = 1'b1;
          end else begin
            ps_next = 1'b1;
          end
        end else begin
          lat_next = lat_reg - 12'h001;
        end
      end
      ST_RES: begin
        // suspend not looked at while resuming
        if (lat_reg == 12'h000) begin
          st_next = ST_RUN;
        end else begin
          lat_next = lat_reg - 12'h001;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg         <= ST_IDLE;
      lat_reg        <= 12'h000;
      kind_erase_reg <= 1'b0;
      ps_reg         <= 1'b0;
      es_reg         <= 1'b0;
      suspend_flag_reg       <= 1'b0;
    end else begin
      st_reg         <= st_next;
      lat_reg        <= lat_next;
      kind_erase_reg <= kind_erase_next;
      ps_reg         <= ps_next;
      es_reg         <= es_next;
      suspend_flag_reg       <= suspend_flag_next;
    end
  end

  // flags always readable, reads never blocked
  assign suspend_flag_o           = suspend_flag_reg;
  assign erase_suspended_flag_o   = es_reg;
  assign program_suspended_flag_o = ps_reg;
  assign device_active_flag_o     = ~st_reg[0];
  // engine halts at once; flags follow after the latency
  assign run_program_o            = st_reg[1] & ~kind_erase_reg;
  assign run_erase_o              = st_reg[1] & kind_erase_reg;

  //////////////////////////////////////////////////////////////////////////////
  // wrap setting and burst address

  reg         wrap_dis_reg;
  reg  [1:0]  wrap_sel_reg;
  reg  [23:0] baddr_reg;
  reg  [6:0]  bcnt_reg;
  reg         undef_reg;
  wire [6:0]  sect_bytes = {1'b0, wrap_mask(wrap_sel_reg)} + 7'h01;

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wrap_dis_reg <= `FSRW_WRAP_DIS_RST;
      wrap_sel_reg <= `FSRW_WRAP_SEL_RST;
    end else if (wrap_cmd) begin
      wrap_dis_reg <= wbyte_reg[`FSRW_WRAP_DIS_BIT];
      wrap_sel_reg <= wbyte_reg[`FSRW_WRAP_SEL_HI:`FSRW_WRAP_SEL_LO];
    end
  end

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      baddr_reg <= 24'h000000;
      bcnt_reg  <= 7'h00;
      undef_reg <= 1'b0;
    end else begin
      // a plain flag; the read path itself is not held off
      // data from a suspended area is undefined
      undef_reg <= rd_in_suspend_flag_area_i & (ps_reg | es_reg);
      if (burst_load_i) begin
        baddr_reg <= burst_addr_i;
        bcnt_reg  <= 7'h01;
      end else if (burst_step_i) begin
        baddr_reg <= burst_next(baddr_reg, wrap_dis_reg, wrap_sel_reg);
        if (bcnt_reg != 7'h7f) begin
          bcnt_reg <= bcnt_reg + 7'h01;
        end
      end
    end
  end

  assign wrap_enable_o        = ~wrap_dis_reg;
  assign wrap_len_o           = wrap_sel_reg;
  assign burst_addr_o         = baddr_reg;
  // whole section returned once count reaches its size
  assign burst_section_done_o = ~wrap_dis_reg &&
                                (bcnt_reg == sect_bytes);
  assign rd_data_undefined_o  = undef_reg;

endmodule // fsrw_core
`default_nettype wire

//--- core/fsrw_map.vh
`ifndef FSRW_MAP_VH
`define FSRW_MAP_VH
// opcodes
`define FSRW_OP_SUSPEND_FLAG_A   8'hb0
`define FSRW_OP_SUSPEND_FLAG_B   8'h75
`define FSRW_OP_RES_A    8'h7a
`define FSRW_OP_RES_B    8'hd0
`define FSRW_OP_WRAP     8'h77
// frame clock counts
`define FSRW_OPC_CLKS    6'h08
`define FSRW_WRAP_HI_CLK 6'h0f
`define FSRW_WRAP_LO_CLK 6'h10
// wrap byte field positions
`define FSRW_WRAP_DIS_BIT 4
`define FSRW_WRAP_SEL_HI  6
`define FSRW_WRAP_SEL_LO  5
// reset values
`define FSRW_WRAP_DIS_RST 1'b1
`define FSRW_WRAP_SEL_RST 2'h0
// latencies in ns, plain defaults; counts round down (shortest times)
`define FSRW_CLK_NS       8
`define FSRW_T_SUSPEND_FLAG_NS    20000
`define FSRW_T_RES_NS     20000
`define FSRW_SUSPEND_FLAG_CYC     (`FSRW_T_SUSPEND_FLAG_NS / `FSRW_CLK_NS)
`define FSRW_RES_CYC      (`FSRW_T_RES_NS / `FSRW_CLK_NS)
`endif

//--- testbench/fsrw_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fsrw_checker (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        burst_load_i,
  input wire logic        burst_step_i,
  input wire logic        rd_in_suspend_flag_area_i,
  input wire logic        suspend_flag_o,
  input wire logic        erase_suspended_flag_o,
  input wire logic        program_suspended_flag_o,
  input wire logic        device_active_flag_o,
  input wire logic        run_program_o,
  input wire logic        run_erase_o,
  input wire logic        wrap_enable_o,
  input wire logic [1:0]  wrap_len_o,
  input wire logic [23:0] burst_addr_o,
  input wire logic        rd_data_undefined_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_resume_seen;
    $fell(program_suspended_flag_o) || $fell(erase_suspended_flag_o);
  endsequence
  a_wrap_off_reset: assert property ($fell(rst_i) |-> !wrap_enable_o && wrap_len_o == 2'h0)
    else $error("wrap on after reset");
  a_suspend_flag_flags_ready: assert property ($rose(erase_suspended_flag_o) || $rose(program_suspended_flag_o)
    |-> suspend_flag_o && !device_active_flag_o)
    else $error("suspend flags or ready wrong");
  a_resume_sets_busy: assert property (s_resume_seen |-> device_active_flag_o)
    else $error("resume without busy");
  // engine stays parked for a while: latency is thousands of cycles
  a_resume_waits: assert property (s_resume_seen |=> (!run_program_o && !run_erase_o) [*8])
    else $error("resumed op ran at once");
  a_erase_after_prog: assert property ($fell(erase_suspended_flag_o) |-> !program_suspended_flag_o)
    else $error("erase resumed before program");
  a_no_erase_ps: assert property (program_suspended_flag_o |-> !run_erase_o)
    else $error("erase ran during program suspend");
  a_undef_read: assert property (rd_in_suspend_flag_area_i && (erase_suspended_flag_o || program_suspended_flag_o)
    |=> rd_data_undefined_o)
    else $error("suspended area read not flagged");
  a_wrap_stays_in: assert property (wrap_enable_o && burst_step_i && !burst_load_i
    |=> burst_addr_o[23:6] == $past(burst_addr_o[23:6]))
    else $error("wrapped burst left its section");
  a_linear_step: assert property (!wrap_enable_o && burst_step_i && !burst_load_i
    |=> burst_addr_o == $past(burst_addr_o) + 24'h1)
    else $error("linear burst did not advance by one");
  a_resume_from_idle: assert property (s_resume_seen |-> !$past(device_active_flag_o))
    else $error("resume taken while busy");
endmodule // fsrw_checker
bind fsrw_core fsrw_checker i_chk (.clk_sys_i, .rst_i, .burst_load_i, .burst_step_i, .rd_in_suspend_flag_area_i,
  .suspend_flag_o, .erase_suspended_flag_o, .program_suspended_flag_o, .device_active_flag_o, .run_program_o,
  .run_erase_o, .wrap_enable_o, .wrap_len_o, .burst_addr_o, .rd_data_undefined_o);
`default_nettype wire

//--- testbench/fsrw_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsrw_map.vh"
module fsrw_spi_host (
  output var logic       cs_n_o,
  output var logic       sck_o,
  output var logic [3:0] io_o
);
  initial begin
    cs_n_o = 1'h1;
    sck_o  = 1'h0;
    io_o   = 4'h5;
  end
  // sck stands low outside frames, 160 ns period inside
  task automatic nib(input logic [3:0] v);
    io_o = v;
    #80 sck_o = 1'h1;
    #80 sck_o = 1'h0;
  endtask
  // opcode msb first on single line
  task automatic op(input logic [7:0] v, input int n);
    #37 cs_n_o = 1'h0;
    for (int i = 0; i < n; i++)
      nib({~io_o[3:1], v[7 - i]});
  endtask
  task automatic close;
    #80 cs_n_o = 1'h1;
    io_o = ~io_o;
  endtask
  task automatic send_op(input logic [7:0] v, input int n);
    op(v, n);
    close;
  endtask
  // quad address junk, then wrap byte
  task automatic send_wrap(input logic [7:0] w);
    op(`FSRW_OP_WRAP, 8);
    repeat (6) nib(~io_o);
    nib(w[7:4]);
    nib(w[3:0]);
    close;
  endtask
endmodule // fsrw_spi_host
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsrw_map.vh"
module testbench;
  logic clk_sys_i = 1'h0;
  logic rst_i = 1'h1;
  logic prog_i = 1'h0, erase_i = 1'h0, fin_i = 1'h0, nosusp_i = 1'h0, rd_i = 1'h0, load_i = 1'h0, step_i = 1'h0;
  logic [23:0] addr_i = 24'h001004;
  wire logic cs_n, sck, suspend_flag, es, ps, busy, run_p, run_e, wen, done, undef;
  wire logic [3:0] io;
  wire logic [1:0] wlen;
  wire logic [23:0] addr;
  int errors = 0, checked = 0, cycles = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  fsrw_spi_host i_host (.cs_n_o(cs_n), .sck_o(sck), .io_o(io));
  fsrw_core i_dut (.clk_sys_i, .rst_i, .cs_n_i(cs_n), .sck_i(sck), .io_i(io), .prog_start_i(prog_i),
    .erase_start_i(erase_i), .op_finish_i(fin_i), .nosusp_op_i(nosusp_i), .rd_in_suspend_flag_area_i(rd_i),
    .burst_load_i(load_i), .burst_addr_i(addr_i), .burst_step_i(step_i), .suspend_flag_o(suspend_flag),
    .erase_suspended_flag_o(es), .program_suspended_flag_o(ps), .device_active_flag_o(busy),
    .run_program_o(run_p), .run_erase_o(run_e), .wrap_enable_o(wen), .wrap_len_o(wlen),
    .burst_addr_o(addr), .burst_section_done_o(done), .rd_data_undefined_o(undef));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_suspend;
    erase_i = 1'h1;
    tick(1);
    erase_i = 1'h0;
    i_host.send_op(`FSRW_OP_RES_A, 8);
    tick(10);
    chk("resume while busy", run_e, 1'h1);
    i_host.send_op(`FSRW_OP_SUSPEND_FLAG_A, 7);
    tick(10);
    chk("short frame", run_e, 1'h1);
    nosusp_i = 1'h1;
    i_host.send_op(`FSRW_OP_SUSPEND_FLAG_A, 8);
    tick(10);
    chk("locked op", run_e, 1'h1);
    nosusp_i = 1'h0;
    i_host.send_op(`FSRW_OP_SUSPEND_FLAG_B, 8);
    tick(2600);
    chk("es", es, 1'h1);
    chk("suspend_flag", suspend_flag, 1'h1);
    chk("ready", busy, 1'h0);
    rd_i = 1'h1;
    tick(1);
    chk("undefined", undef, 1'h1);
    rd_i = 1'h0;
    tick(1);
    chk("undefined off", undef, 1'h0);
  endtask
  // both suspended: program resumes first, erase needs a second resume
  task automatic t_nested;
    prog_i = 1'h1;
    tick(1);
    prog_i = 1'h0;
    chk("prog in erase suspend_flag", run_p, 1'h1);
    chk("es during prog", es, 1'h1);
    i_host.send_op(`FSRW_OP_SUSPEND_FLAG_A, 8);
    tick(2600);
    chk("ps", ps, 1'h1);
    erase_i = 1'h1;
    tick(1);
    erase_i = 1'h0;
    chk("erase blocked", run_e, 1'h0);
    i_host.send_op(`FSRW_OP_RES_B, 7);
    tick(10);
    chk("short resume", ps, 1'h1);
    i_host.send_op(`FSRW_OP_RES_B, 8);
    tick(10);
    chk("ps cleared", ps, 1'h0);
    chk("es kept", es, 1'h1);
    chk("busy", busy, 1'h1);
    i_host.send_op(`FSRW_OP_SUSPEND_FLAG_A, 8);
    tick(2600);
    chk("suspend_flag while resuming", run_p, 1'h1);
    fin_i = 1'h1;
    tick(1);
    fin_i = 1'h0;
    i_host.send_op(`FSRW_OP_RES_A, 8);
    tick(10);
    chk("es cleared", es, 1'h0);
    chk("suspend_flag cleared", suspend_flag, 1'h0);
    tick(2600);
    chk("erase runs", run_e, 1'h1);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_wrap;
    for (int l = 0; l < 4; l++) begin
      i_host.send_wrap({1'h0, l[1:0], 5'h00});
      tick(10);
      chk("wrap len", wlen, l[1:0]);
      chk("wrap on", wen, 1'h1);
    end
    i_host.send_wrap(8'h20);
    tick(10);
    load_i = 1'h1;
    tick(1);
    load_i = 1'h0;
    step_i = 1'h1;
    for (int i = 1; i < 16; i++) begin
      tick(1);
      chk("wrap addr", addr, 24'h001000 | ((4 + i) & 15));
      chk("section done", done, i == 15);
    end
    step_i = 1'h0;
    chk("section done", done, 1'h1);
    i_host.send_wrap(8'h10);
    tick(10);
    chk("wrap off", wen, 1'h0);
    step_i = 1'h1;
    tick(1);
    step_i = 1'h0;
    chk("linear addr", addr, 24'h001004);
  endtask
  // mid-run reset drops the wrap setting again
  task automatic t_reset;
    i_host.send_wrap(8'h40);
    tick(10);
    chk("wrap before reset", wen, 1'h1);
    rst_i = 1'h1;
    tick(2);
    rst_i = 1'h0;
    chk("wrap after reset", {wlen, wen}, 3'h0);
    tick(2);
  endtask
  ////////////////////////////////////////////////////////////////
  // hang guard: the whole run needs about 15000 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      give_verdict;
    end
  end
  initial begin
    tick(6);
    rst_i = 1'h0;
    chk("wrap reset", {wlen, wen}, 3'h0);
    tick(2);
    t_suspend;
    t_nested;
    t_wrap;
    t_reset;
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
